// ===== common/atr_pkg.sv
package atr_pkg;
   // ***************************
   // Timing
   // ***************************
   localparam int unsigned CLK_PERIOD_NS = 10;
   localparam int unsigned TB_RES_NS     = 50;
   localparam int unsigned TB_DIV        = TB_RES_NS / CLK_PERIOD_NS;
   localparam int unsigned TB_HIGH       = 2;
   // ***************************
   // Counter set
   // ***************************
   localparam int unsigned N_CTR24 = 7;
   localparam int unsigned N_CTR16 = 3;
   localparam int unsigned N_CTR   = N_CTR24 + N_CTR16;
   localparam int unsigned W24     = 24;
   localparam int unsigned W16     = 16;
   localparam logic [23:0] LOAD_RST = 24'h000013;
   // ***************************
   // Register map
   // ***************************
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_SRC  = 8'h04;
   localparam logic [7:0] OFF_STAT = 8'h08;
   localparam logic [7:0] OFF_TCF  = 8'h0C;
   localparam logic [7:0] OFF_CEN  = 8'h10;
   localparam logic [7:0] OFF_LOAD = 8'h40;
   localparam logic [7:0] OFF_CNT  = 8'h80;
   localparam logic [31:0] CTRL_RST = 32'h00000000;
   localparam logic [31:0] SRC_RST  = 32'h00000000;
   localparam int unsigned CB_TB_SEL = 0;
   localparam int unsigned CB_TB_DRV = 1;
   localparam int unsigned CB_SYNC   = 2;
   localparam int unsigned CB_START  = 3;
   localparam int unsigned CB_STOP   = 4;
   localparam int unsigned CB_OFRONT = 5;
   localparam int unsigned CB_OTRIG  = 6;
   localparam int unsigned CB_PAUSE  = 7;
   localparam int unsigned SF_CONV   = 0;
   localparam int unsigned SF_START  = 4;
   localparam int unsigned SF_PAUSE  = 8;
   localparam int unsigned SF_STB    = 12;
   localparam int unsigned SF_OLINE  = 16;
   localparam logic [1:0] RESP_OK  = 2'h0;
   localparam logic [1:0] RESP_ERR = 2'h2;
   // ***************************
   // Types
   // ***************************
   typedef logic [3:0] atr_src_t;
   localparam atr_src_t SRC_INT   = 4'h0;
   localparam atr_src_t SRC_FRONT = 4'h1;
   localparam atr_src_t SRC_STAR  = 4'h8;
   typedef enum logic [2:0] {
      ST_IDLE  = 3'b001,
      ST_RUN   = 3'b010,
      ST_PAUSE = 3'b100
   } atr_state_e;
endpackage

// ===== dv/atr_far_model.sv
`timescale 1ns/1ps
module atr_far_model (
   input  wire logic       sys_clk_i,
   input  wire logic       go_i,
   input  wire logic [3:0] code_i,
   output logic            front_o,
   output logic [5:0]      trig_o,
   output logic            star_o,
   output logic            trig7_o,
   output logic            bus_clk_o
);
   // ***************************
   // Trigger source
   // ***************************
   logic [2:0] hold_q;
   // Lines idle low; bus clock stands still except for one pulse on request
   assign trig7_o   = (hold_q != 3'h0) && (code_i == 4'h9);
   assign bus_clk_o = (hold_q != 3'h0) && (code_i == 4'hA);
   always_ff @(posedge sys_clk_i) begin
      hold_q <= go_i ? 3'h4 : (hold_q != 3'h0 ? hold_q - 3'h1 : 3'h0);
   end
   // Pulse held 4 cycles so the two-stage sync surely sees it
   assign front_o = (hold_q != 3'h0) && (code_i == 4'h1);
   assign star_o  = (hold_q != 3'h0) && (code_i == 4'h8);
   always_comb begin
      trig_o = 6'h00;
      if (hold_q != 3'h0 && code_i >= 4'h2 && code_i <= 4'h7) trig_o[code_i - 4'h2] = 1'b1;
   end
endmodule // atr_far_model

// ===== dv/tb_acquisition_timing_router.sv
`timescale 1ns/1ps
module tb_acquisition_timing_router;
   logic clk = 1'b0, nrst = 1'b0, go = 1'b0, fr, t7, st, bc;
   logic [3:0] code = 4'h0;
   logic [5:0] tr;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic aw = 1'b0, w = 1'b0, bq = 1'b1, ar = 1'b0, rq = 1'b1;
   logic [31:0] wd = 32'h0, rd;
   logic [1:0] rs;
   wire awr, wr_, bv, arr, rv, cc, sh, stt, run, oen, fo, foe, bco, sc;
   wire [1:0] br, rr;
   wire [31:0] rdt;
   wire [5:0] to, toe;
   int n_mismatch = 0, n_tests = 0, lfsr = 15;
   atr_far_model i_far (.sys_clk_i(clk), .go_i(go), .code_i(code), .front_o(fr), .trig_o(tr),
      .star_o(st), .trig7_o(t7), .bus_clk_o(bc));
   atr_top i_dut (.sys_clk_i(clk), .nrst_i(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(aw),
      .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(w), .s_axi_wready(wr_),
      .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bq), .s_axi_araddr(ara), .s_axi_arvalid(ar),
      .s_axi_arready(arr), .s_axi_rdata(rdt), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rq),
      .front_function_input_i(fr), .front_function_out_o(fo), .front_function_oe_n_o(foe), .trig_i(tr),
      .trig_o(to), .trig_oe_n_o(toe), .trig7_i(t7), .star_trig_i(st), .bus_clk_i(bc), .bus_clk_o(bco),
      .bus_clk_oe_n_o(oen), .convert_clock_o(cc), .sample_clock_o(sc), .acquisition_start_trigger_o(stt),
      .sample_held_indication_o(sh), .acq_running_o(run));
   initial forever #5 clk = ~clk;
   function automatic int xs();
      lfsr = lfsr ^ (lfsr << 13);
      lfsr = lfsr ^ (lfsr >> 17);
      lfsr = lfsr ^ (lfsr << 5);
      return lfsr;
   endfunction
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // ***************************
   // Register bus master
   // ***************************
   task automatic wreg(input logic [7:0] a, input logic [31:0] d);
      bit pa, pw, pb, ha, hw, hb;
      int t;
      pa = 1; pw = 1; pb = 1; t = 0;
      awa <= a; wd <= d; aw <= 1'b1; w <= 1'b1;
      while (pb && t < 50) begin
         @(negedge clk);
         ha = pa && awr; hw = pw && wr_; hb = bv;
         @(posedge clk);
         if (ha) begin aw <= 1'b0; pa = 0; end
         if (hw) begin w <= 1'b0; pw = 0; end
         if (hb && !pa && !pw) pb = 0;
         t++;
      end
      if (pb) begin n_mismatch++; $display("mismatch at %0t: write got no answer", $time); end
   endtask
   task automatic rreg(input logic [7:0] a);
      bit pa, ha;
      int t;
      pa = 1; t = 0; rs = 2'h3;
      ara <= a; ar <= 1'b1;
      while (rs === 2'h3 && t < 50) begin
         @(negedge clk);
         ha = pa && arr;
         if (rv && !pa) begin rd = rdt; rs = rr; end
         @(posedge clk);
         if (ha) begin ar <= 1'b0; pa = 0; end
         t++;
      end
      if (rs === 2'h3) begin n_mismatch++; $display("mismatch at %0t: read got no answer", $time); end
   endtask
   // Counts cycles until the next convert (s=0) or sample (s=1) pulse, at most 400
   task automatic gap(input bit s, output int n);
      n = 0;
      do begin @(negedge clk); n++; end while (!(s ? sc : cc) && n < 400);
   endtask
   task automatic final_report();
      $display("counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      final_report();
   end
   // ***************************
   // Tests
   // ***************************
   initial begin
      int n, l;
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rreg(8'h00); cmp(rd, 32'h0);
      rreg(8'h08); cmp(rd[3:0], 4'h1);
      rreg(8'h40); cmp(rd, 32'h13);
      cmp(oen, 1'b1);
      rreg(8'hFC); cmp(rs, atr_pkg::RESP_ERR);
      wreg(8'h00, 32'h2); @(negedge clk); cmp(oen, 1'b0);
      @(posedge clk); wreg(8'h00, 32'h1); rreg(8'h08); cmp(rd[3], 1'b1);
      wreg(8'h00, 32'h4);
      code <= 4'h9; go <= 1'b1;
      @(posedge clk); go <= 1'b0;
      // Line seven edge zeroes the divider phase, so the clock out pattern is known
      repeat (3) @(posedge clk);
      for (int k = 0; k < atr_pkg::TB_DIV; k++) begin
         @(posedge clk); @(negedge clk); cmp(bco, k < atr_pkg::TB_HIGH);
      end
      @(posedge clk); wreg(8'h00, 32'h60);
      $display("test registers done");
      for (int c = 1; c <= 8; c++) begin
         wreg(8'h04, 32'(c) << 4);
         code <= 4'(c); go <= 1'b1;
         @(posedge clk); go <= 1'b0;
         n = 0;
         do begin @(negedge clk); n++; end while (!stt && n < 20);
         cmp(stt, 1'b1);
         cmp(to, 6'h3F);
         cmp({fo, foe, toe}, {1'b1, 1'b0, ~6'h01});
         @(posedge clk); @(negedge clk); cmp(run, 1'b1);
         @(posedge clk); wreg(8'h00, 32'h70);
      end
      $display("test start sources done");
      l = 2 + (xs() & 7);
      wreg(8'h40, 32'(l)); wreg(8'h04, 32'h0); wreg(8'h00, 32'h8);
      gap(0, n); gap(0, n); cmp(n, (l + 1) * atr_pkg::TB_DIV);
      @(negedge clk); cmp(sh, 1'b1);
      @(posedge clk); wreg(8'h40, 32'(l + 3));
      gap(0, n); gap(0, n); gap(0, n); cmp(n, (l + 4) * atr_pkg::TB_DIV);
      @(posedge clk); wreg(8'h00, 32'h80); rreg(8'h08); cmp(rd[2:0], 3'h4);
      wreg(8'h00, 32'h0); rreg(8'h08); cmp(rd[2:0], 3'h2);
      gap(1, n); gap(1, n); cmp(n, (atr_pkg::LOAD_RST + 1) * atr_pkg::TB_DIV);
      @(posedge clk); wreg(8'h00, 32'h10);
      $display("test convert clock done");
      // Backplane timebase selected: no tick until the far side offers a clock edge
      wreg(8'h40, 32'h0); wreg(8'h00, 32'h9);
      gap(0, n); cmp(n, 400);
      @(posedge clk); code <= 4'hA; go <= 1'b1;
      @(posedge clk); go <= 1'b0;
      gap(0, n); cmp(n < 10, 1'b1);
      @(posedge clk); wreg(8'h00, 32'h10);
      $display("test backplane timebase done");
      final_report();
   end
endmodule // tb_acquisition_timing_router

// ===== src/atr_counter.sv
`timescale 1ns/1ps
module atr_counter #(
   parameter int unsigned W = 24
) (
   input  wire logic         sys_clk_i,
   input  wire logic         nrst_i,
   input  wire logic         en_i,
   input  wire logic         tick_i,
   input  wire logic [W-1:0] load_i,
   output logic      [W-1:0] count_o,
   output logic              tc_o
);
   logic [W-1:0] count_q;
   logic         tc_q;

   // New load value applies at the next wrap, so the rate can change mid-run
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         count_q <= '0;
         tc_q    <= 1'b0;
      end else begin
         tc_q <= 1'b0;
         if (!en_i) begin
            count_q <= load_i;
         end else if (tick_i) begin
            if (count_q == '0) begin
               count_q <= load_i;
               tc_q    <= 1'b1;
            end else begin
               count_q <= count_q - 1'b1;
            end
         end
      end
   end

   assign count_o = count_q;
   assign tc_o    = tc_q;

   reload_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      tc_o |-> count_o == $past(load_i))
      else $error("counter did not reload on wrap");
endmodule // atr_counter

// ===== src/atr_sync.sv
`timescale 1ns/1ps
module atr_sync #(
   parameter int unsigned W = 10
) (
   input  wire logic         sys_clk_i,
   input  wire logic         nrst_i,
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] level_o,
   output logic      [W-1:0] rise_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] prev_q;

   // Only sync_q looks at meta_q
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         meta_q <= '0;
         sync_q <= '0;
         prev_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   assign level_o = sync_q;
   assign rise_o  = sync_q & ~prev_q;

   rise_once_a: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
      rise_o[0] |=> !rise_o[0])
      else $error("edge pulse lasted two cycles");
endmodule // atr_sync

// ===== src/atr_top.sv
`timescale 1ns/1ps
// What this block does
// - Master timebase is internal 20 MHz or the backplane clock, chosen by software.
// - Internal timebase may be driven onto the backplane clock line.
// - The selected timebase paces every counter, except counter 1 when its sample source is external.
// - Reset selects internal timebase and does not drive the backplane clock.
// - Trigger line seven resynchronises the master timebase phase.
// - Convert clock source: front input, trigger 0-5, star, or counter zero.
// - Any timing signal may use the front input, several at once.
// - Each timing signal selects an external or internal source.
// - Seven 24-bit and three 16-bit counters.
// - Counter resolution is one timebase period, 50 ns on the internal timebase.
// - Sample rate may change mid-acquisition without stopping samples.
// - Start trigger from front input or trigger bus begins acquisition.
// - Start trigger acted on is driven out to front pin or bus.
// - Pause trigger suspends sampling while active, resumes on release.
// - External sample clock timebase may drive the sample clocks.
// - Hold-complete pulse is produced but not routed to pins.
// - Triggers are accepted on the star trigger line.
module atr_top (
   input  wire logic        sys_clk_i,
   input  wire logic        nrst_i,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        front_function_input_i,
   output logic             front_function_out_o,
   output logic             front_function_oe_n_o,
   input  wire logic [5:0]  trig_i,
   output logic [5:0]       trig_o,
   output logic [5:0]       trig_oe_n_o,
   input  wire logic        trig7_i,
   input  wire logic        star_trig_i,
   input  wire logic        bus_clk_i,
   output logic             bus_clk_o,
   output logic             bus_clk_oe_n_o,
   output logic             convert_clock_o,
   output logic             sample_clock_o,
   output logic             acquisition_start_trigger_o,
   output logic             sample_held_indication_o,
   output logic             acq_running_o
);
   localparam int unsigned NC = atr_pkg::N_CTR;

   // ***************************
   // Helpers
   // ***************************
   function automatic logic pick(atr_pkg::atr_src_t s, logic [7:0] ext, logic intl);
      logic r;
      r = 1'b0;
      if (s == atr_pkg::SRC_INT) begin
         r = intl;
      end else if (s <= atr_pkg::SRC_STAR) begin
         r = ext[3'(s - 4'h1)];
      end
      return r;
   endfunction

   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw, logic [3:0] st);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (st[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic in_range(logic [7:0] a, logic [7:0] base);
      return a >= base && a < base + 8'(NC * 4);
   endfunction

   function automatic logic mapped(logic [7:0] a);
      return a == atr_pkg::OFF_CTRL || a == atr_pkg::OFF_SRC || a == atr_pkg::OFF_STAT ||
             a == atr_pkg::OFF_TCF || a == atr_pkg::OFF_CEN ||
             in_range(a, atr_pkg::OFF_LOAD) || in_range(a, atr_pkg::OFF_CNT);
   endfunction

   // ***************************
   // Input synchronisers
   // ***************************
   logic [9:0] lvl;
   logic [9:0] rise;

   atr_sync #(.W(10)) u_sync (
      .sys_clk_i (sys_clk_i),
      .nrst_i    (nrst_i),
      .async_i   ({bus_clk_i, trig7_i, star_trig_i, trig_i, front_function_input_i}),
      .level_o   (lvl),
      .rise_o    (rise)
   );

   // ***************************
   // Registers and bus slave
   // ***************************
   logic [31:0]     ctrl_q;
   logic [31:0]     src_q;
   logic [NC-1:0]   cen_q;
   logic [NC-1:0]   tcf_q;
   logic [23:0]     load_q [NC];
   logic [23:0]     cnt [NC];
   logic [NC-1:0]   tc;
   logic            aw_hold_q;
   logic            w_hold_q;
   logic [7:0]      aw_addr_q;
   logic [31:0]     w_data_q;
   logic [3:0]      w_strb_q;
   logic            bvalid_q;
   logic [1:0]      bresp_q;
   logic            rvalid_q;
   logic [1:0]      rresp_q;
   logic [31:0]     rdata_q;
   logic            wr_go;
   logic            start_sw_q;
   logic            stop_sw_q;
   logic [31:0]     rd_mux;
   atr_pkg::atr_state_e st_q;

   assign s_axi_awready = !aw_hold_q && !bvalid_q;
   assign s_axi_wready  = !w_hold_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign wr_go         = aw_hold_q && w_hold_q;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         aw_hold_q <= 1'b0;
         w_hold_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h00000000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= atr_pkg::RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            bvalid_q  <= 1'b1;
            bresp_q   <= mapped(aw_addr_q) ? atr_pkg::RESP_OK : atr_pkg::RESP_ERR;
         end else if (bvalid_q && s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   always_comb begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr)
         atr_pkg::OFF_CTRL: rd_mux = ctrl_q;
         atr_pkg::OFF_SRC:  rd_mux = src_q;
         atr_pkg::OFF_STAT: rd_mux = {28'h0000000, ctrl_q[atr_pkg::CB_TB_SEL], st_q};
         atr_pkg::OFF_TCF:  rd_mux = 32'(tcf_q);
         atr_pkg::OFF_CEN:  rd_mux = 32'(cen_q);
         default: begin
            for (int i = 0; i < NC; i++) begin
               if (s_axi_araddr == atr_pkg::OFF_LOAD + 8'(i * 4)) begin
                  rd_mux = 32'(load_q[i]);
               end
               if (s_axi_araddr == atr_pkg::OFF_CNT + 8'(i * 4)) begin
                  rd_mux = 32'(cnt[i]);
               end
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rvalid_q <= 1'b0;
         rresp_q  <= atr_pkg::RESP_OK;
         rdata_q  <= 32'h00000000;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_q <= 1'b1;
         rresp_q  <= mapped(s_axi_araddr) ? atr_pkg::RESP_OK : atr_pkg::RESP_ERR;
         rdata_q  <= rd_mux;
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end

   // Start and stop bits are one-shot commands, never stored
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ctrl_q     <= atr_pkg::CTRL_RST;
         src_q      <= atr_pkg::SRC_RST;
         cen_q      <= '0;
         start_sw_q <= 1'b0;
         stop_sw_q  <= 1'b0;
         for (int i = 0; i < NC; i++) begin
            load_q[i] <= atr_pkg::LOAD_RST;
         end
      end else begin
         start_sw_q <= 1'b0;
         stop_sw_q  <= 1'b0;
         if (wr_go) begin
            if (aw_addr_q == atr_pkg::OFF_CTRL) begin
               ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q) &
                         ~(32'h1 << atr_pkg::CB_START) & ~(32'h1 << atr_pkg::CB_STOP);
               start_sw_q <= w_strb_q[0] && w_data_q[atr_pkg::CB_START];
               stop_sw_q  <= w_strb_q[0] && w_data_q[atr_pkg::CB_STOP];
            end
            if (aw_addr_q == atr_pkg::OFF_SRC) begin
               src_q <= merge(src_q, w_data_q, w_strb_q);
            end
            if (aw_addr_q == atr_pkg::OFF_CEN) begin
               cen_q <= NC'(merge(32'(cen_q), w_data_q, w_strb_q));
            end
            for (int i = 0; i < NC; i++) begin
               if (aw_addr_q == atr_pkg::OFF_LOAD + 8'(i * 4)) begin
                  load_q[i] <= 24'(merge(32'(load_q[i]), w_data_q, w_strb_q));
               end
            end
         end
      end
   end

   // Set wins over a same-cycle write-one clear
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tcf_q <= '0;
      end else begin
         if (wr_go && aw_addr_q == atr_pkg::OFF_TCF) begin
            tcf_q <= (tcf_q & ~NC'(w_data_q & {32{w_strb_q[0]}})) | tc;
         end else begin
            tcf_q <= tcf_q | tc;
         end
      end
   end

   // ***************************
   // Master timebase
   // ***************************
   logic [2:0] div_q;
   logic       int_tick;
   logic       tb_tick;
   logic       tb_sel;
   logic       tb_drv;

   assign tb_sel   = ctrl_q[atr_pkg::CB_TB_SEL];
   assign tb_drv   = ctrl_q[atr_pkg::CB_TB_DRV] && !tb_sel;
   assign int_tick = div_q == 3'(atr_pkg::TB_DIV - 1);
   assign tb_tick  = tb_sel ? rise[9] : int_tick;

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         div_q <= 3'h0;
      end else if (ctrl_q[atr_pkg::CB_SYNC] && rise[8]) begin
         div_q <= 3'h0;
      end else if (int_tick) begin
         div_q <= 3'h0;
      end else begin
         div_q <= div_q + 3'h1;
      end
   end

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         bus_clk_o      <= 1'b0;
         bus_clk_oe_n_o <= 1'b1;
      end else begin
         bus_clk_o      <= div_q < 3'(atr_pkg::TB_HIGH);
         bus_clk_oe_n_o <= !tb_drv;
      end
   end

   // ***************************
   // Counters
   // ***************************
   logic running;
   logic stb_tick;

   assign running  = st_q == atr_pkg::ST_RUN;
   // Counter 1 paces samples and may run off an external timebase
   assign stb_tick = pick(src_q[atr_pkg::SF_STB +: 4], rise[7:0], tb_tick);

   for (genvar i = 0; i < NC; i++) begin : g_ctr
      localparam int unsigned W = (i < atr_pkg::N_CTR24) ? atr_pkg::W24 : atr_pkg::W16;
      logic [W-1:0] c;
      logic         en;
      logic         tk;
      if (i < 2) begin : g_acq
         assign en = st_q != atr_pkg::ST_IDLE;
         assign tk = running && (i == 1 ? stb_tick : tb_tick);
      end else begin : g_gp
         assign en = cen_q[i];
         assign tk = tb_tick;
      end
      atr_counter #(.W(W)) u_ctr (
         .sys_clk_i (sys_clk_i),
         .nrst_i    (nrst_i),
         .en_i      (en),
         .tick_i    (tk),
         .load_i    (load_q[i][W-1:0]),
         .count_o   (c),
         .tc_o      (tc[i])
      );
      assign cnt[i] = 24'(c);
   end

   // ***************************
   // Acquisition control
   // ***************************
   logic conv_evt;
   logic start_evt;
   logic pause_lvl;
   logic start_act;
   logic [5:0] line_sel;

   assign conv_evt  = pick(src_q[atr_pkg::SF_CONV +: 4], rise[7:0], tc[0]);
   assign start_evt = pick(src_q[atr_pkg::SF_START +: 4], rise[7:0], start_sw_q);
   assign pause_lvl = pick(src_q[atr_pkg::SF_PAUSE +: 4], lvl[7:0], ctrl_q[atr_pkg::CB_PAUSE]);
   assign start_act = st_q == atr_pkg::ST_IDLE && start_evt;
   assign line_sel  = 6'h01 << src_q[atr_pkg::SF_OLINE +: 3];

   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st_q <= atr_pkg::ST_IDLE;
      end else begin
         case (st_q)
            atr_pkg::ST_IDLE: begin
               if (start_act) begin
                  st_q <= atr_pkg::ST_RUN;
               end
            end
            atr_pkg::ST_RUN: begin
               if (stop_sw_q) begin
                  st_q <= atr_pkg::ST_IDLE;
               end else if (pause_lvl) begin
                  st_q <= atr_pkg::ST_PAUSE;
               end
            end
            atr_pkg::ST_PAUSE: begin
               if (stop_sw_q) begin
                  st_q <= atr_pkg::ST_IDLE;
               end else if (!pause_lvl) begin
                  st_q <= atr_pkg::ST_RUN;
               end
            end
            default: st_q <= atr_pkg::ST_IDLE;
         endcase
      end
   end

   // Hold-complete has no pin route; it only leaves as its own port
   always_ff @(posedge sys_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         convert_clock_o             <= 1'b0;
         sample_clock_o              <= 1'b0;
         sample_held_indication_o    <= 1'b0;
         acquisition_start_trigger_o <= 1'b0;
         front_function_oe_n_o       <= 1'b1;
         trig_oe_n_o                 <= 6'h3F;
      end else begin
         convert_clock_o             <= conv_evt && running;
         sample_clock_o              <= tc[1];
         sample_held_indication_o    <= convert_clock_o;
         acquisition_start_trigger_o <= start_act;
         front_function_oe_n_o       <= !ctrl_q[atr_pkg::CB_OFRONT];
         trig_oe_n_o                 <= ctrl_q[atr_pkg::CB_OTRIG] ? ~line_sel : 6'h3F;
      end
   end

   assign front_function_out_o = acquisition_start_trigger_o;
   assign trig_o               = {6{acquisition_start_trigger_o}};
   assign acq_running_o        = running;

   // ***************************
   // Checks
   // ***************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!nrst_i);

   int_space_a: assert property (!tb_sel && tb_tick |=> !tb_tick [*4])
      else $error("internal timebase faster than 50 ns");
   bus_tick_a: assert property (tb_sel && !rise[9] |-> !tb_tick)
      else $error("timebase tick without backplane clock edge");
   drive_a: assert property (!bus_clk_oe_n_o |-> $past(tb_drv))
      else $error("backplane clock driven while not allowed");
   off_rst_a: assert property (disable iff (1'b0)
      $rose(nrst_i) |-> bus_clk_oe_n_o && !tb_sel)
      else $error("reset state of timebase wrong");
   resync_a: assert property (ctrl_q[atr_pkg::CB_SYNC] && rise[8] |=> div_q == 3'h0)
      else $error("line seven did not realign timebase");
   conv_int_a: assert property (running && src_q[3:0] == atr_pkg::SRC_INT && tc[0]
      |=> convert_clock_o)
      else $error("counter zero did not make a convert clock");
   start_go_a: assert property (start_act |=> running && acquisition_start_trigger_o
      ##1 !acquisition_start_trigger_o)
      else $error("start trigger not acted on or not output");
   pause_hold_a: assert property (st_q == atr_pkg::ST_PAUSE ##1 st_q == atr_pkg::ST_PAUSE
      |-> !convert_clock_o && !sample_clock_o)
      else $error("sampling while paused");
   held_a: assert property (convert_clock_o |=> sample_held_indication_o)
      else $error("hold-complete missing after convert");

   start_c: cover property (start_act ##[1:50] convert_clock_o);
   pause_c: cover property (st_q == atr_pkg::ST_PAUSE ##[1:50] running);
   bus_tb_c: cover property (tb_sel && tb_tick);
   rate_c: cover property (running && wr_go && aw_addr_q == atr_pkg::OFF_LOAD + 8'h04);
endmodule // atr_top
